// file: bse_exec.sv
module bse_exec (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  output logic             busy,
  output logic             sleeping
);

  // ****************************************
  // storage
  // ****************************************
  bse_pkg::bse_state_type  state;
  bse_pkg::bse_result_type r;
  logic [7:0]  mem [bse_pkg::MEM_DEPTH];
  logic [31:0] insn;
  logic [23:0] pc;
  logic [23:0] sp;
  logic [7:0]  condition_code_register;
  logic [31:0] greg;
  logic [15:0] count;
  logic [15:0] src;
  logic [15:0] dst;
  logic [7:0]  maddr;
  logic        adv;
  logic        illegal;
  logic [4:0]  cnt;
  logic [1:0]  sub;
  logic [15:0] elapsed;
  logic        move_word;

  function automatic logic [7:0] rd8(input logic [23:0] a);
    return mem[a[7:0]];
  endfunction

  function automatic logic [15:0] rd16(input logic [23:0] a);
    return {rd8(a), rd8(a + 24'd1)};
  endfunction

  function automatic logic [23:0] rd24(input logic [23:0] a);
    return {rd8(a + 24'd1), rd16(a + 24'd2)};
  endfunction

  function automatic logic cond_true(input logic [3:0] c, input logic [7:0] f);
    logic t;
    t = 1'b1;
    case (c[3:1])
      3'd0: t = 1'b1;
      3'd1: t = ~(f[bse_pkg::CCR_C] | f[bse_pkg::CCR_Z]);
      3'd2: t = ~f[bse_pkg::CCR_C];
      3'd3: t = ~f[bse_pkg::CCR_Z];
      3'd4: t = ~f[bse_pkg::CCR_V];
      3'd5: t = ~f[bse_pkg::CCR_N];
      3'd6: t = ~(f[bse_pkg::CCR_N] ^ f[bse_pkg::CCR_V]);
      default: t = ~(f[bse_pkg::CCR_Z] | (f[bse_pkg::CCR_N] ^ f[bse_pkg::CCR_V]));
    endcase
    // odd condition codes are the inverse of their even partner
    return c[0] ? ~t : t;
  endfunction

  // ****************************************
  // decode and result
  // ****************************************
  logic [7:0]  b0;
  logic [7:0]  b1;
  logic [7:0]  b2;
  logic [7:0]  b3;
  logic [23:0] disp8;
  logic [23:0] disp16;
  logic        push_en;
  logic [23:0] push_val;

  assign b0 = insn[31:24];
  assign b1 = insn[23:16];
  assign b2 = insn[15:8];
  assign b3 = insn[7:0];
  assign disp8  = {{16{b1[7]}}, b1};
  assign disp16 = {{8{b2[7]}}, b2, b3};

  always_comb begin
    r          = '0;
    r.pc       = pc + 24'd2;
    r.sp       = sp;
    r.condition_code_register      = condition_code_register;
    r.greg     = greg;
    r.states   = bse_pkg::ST_SHORT;
    push_en    = 1'b0;
    push_val   = pc + 24'd2;
    case (b0)
      bse_pkg::OP_NOP: begin
        r.illegal = (b1 != 8'h00);
      end
      bse_pkg::OP_SYS: begin
        if (b1 == bse_pkg::SUB_SLEEP) begin
          r.sleep = 1'b1;
        end else if (b1 == bse_pkg::SUB_CCR_MEM && b2 == bse_pkg::SUB_IND) begin
          r.pc     = pc + 24'd4;
          r.states = bse_pkg::ST_FLAGS_IND;
          if (b3[7]) begin
            r.wr_addr = greg[23:0];
            r.wr_data = {condition_code_register, condition_code_register, 16'h0000};
            r.wr_len  = 3'd2;
          end else begin
            r.condition_code_register = rd8(greg[23:0]);
          end
        end else if (b1 == bse_pkg::SUB_CCR_MEM && b2 == bse_pkg::SUB_PTR) begin
          r.pc     = pc + 24'd4;
          r.states = bse_pkg::ST_FLAGS_PTR;
          if (b3[7]) begin
            r.greg    = greg - 32'd2;
            r.wr_addr = 24'(greg - 32'd2);
            r.wr_data = {condition_code_register, condition_code_register, 16'h0000};
            r.wr_len  = 3'd2;
          end else begin
            r.condition_code_register  = rd8(greg[23:0]);
            r.greg = greg + 32'd2;
          end
        end else begin
          r.illegal = 1'b1;
        end
      end
      bse_pkg::OP_STC_REG: r.greg = {greg[31:8], condition_code_register};
      bse_pkg::OP_LDC_REG: r.condition_code_register = greg[7:0];
      bse_pkg::OP_LDC_IMM: r.condition_code_register = b1;
      bse_pkg::OP_OR_CCR:  r.condition_code_register = condition_code_register | b1;
      bse_pkg::OP_XOR_CCR: r.condition_code_register = condition_code_register ^ b1;
      bse_pkg::OP_AND_CCR: r.condition_code_register = condition_code_register & b1;
      bse_pkg::OP_RTS: begin
        r.illegal = (b1 != bse_pkg::SUB_RET);
        r.states  = adv ? bse_pkg::ST_RET_A : bse_pkg::ST_RET_N;
        r.pc      = adv ? rd24(sp) : {8'h00, rd16(sp)};
        r.sp      = adv ? sp + 24'd4 : sp + 24'd2;
      end
      bse_pkg::OP_RTE: begin
        r.illegal = (b1 != bse_pkg::SUB_RET);
        r.states  = bse_pkg::ST_RTE;
        r.condition_code_register     = rd8(sp);
        r.pc      = adv ? {rd8(sp + 24'd1), rd16(sp + 24'd2)} : {8'h00, rd16(sp + 24'd2)};
        r.sp      = sp + 24'd4;
      end
      bse_pkg::OP_TRAP: begin
        // stack PC and CONDITION_CODE_REGISTER, mask, vector
        r.states  = adv ? bse_pkg::ST_TRAP_A : bse_pkg::ST_TRAP_N;
        r.sp      = sp - 24'd4;
        r.wr_addr = sp - 24'd4;
        r.wr_len  = 3'd4;
        r.wr_data = adv ? {condition_code_register, push_val} : {condition_code_register, condition_code_register, push_val[15:0]};
        r.condition_code_register[bse_pkg::CCR_I] = 1'b1;
        if (adv) begin
          r.pc = rd24(24'(bse_pkg::VEC_BASE) + {20'h00000, b1[5:4], 2'b00});
        end else begin
          r.pc = {8'h00, rd16(24'(bse_pkg::VEC_BASE) + {21'h000000, b1[5:4], 1'b0})};
        end
      end
      bse_pkg::OP_BCC_LONG: begin
        // condition in upper nibble of second byte
        r.illegal = (b1[3:0] != 4'h0);
        r.states  = bse_pkg::ST_BCC_LONG;
        r.pc = cond_true(b1[7:4], condition_code_register) ? pc + 24'd4 + disp16 : pc + 24'd4;
      end
      bse_pkg::OP_JMP_REG: begin
        r.states = bse_pkg::ST_JMP_REG;
        r.pc     = greg[23:0];
      end
      bse_pkg::OP_JMP_ABS: begin
        r.states = bse_pkg::ST_JMP_ABS;
        r.pc     = {b1, b2, b3};
      end
      bse_pkg::OP_JMP_IND: begin
        r.states = adv ? bse_pkg::ST_JMP_IND_A : bse_pkg::ST_JMP_IND_N;
        r.pc     = adv ? rd24({16'h0000, b1}) : {8'h00, rd16({16'h0000, b1})};
      end
      bse_pkg::OP_BSR8: begin
        push_en  = 1'b1;
        r.states = adv ? bse_pkg::ST_BSR_A : bse_pkg::ST_BSR_N;
        r.pc     = pc + 24'd2 + disp8;
      end
      bse_pkg::OP_BSR16: begin
        push_en   = 1'b1;
        push_val  = pc + 24'd4;
        r.illegal = (b1 != 8'h00);
        r.states  = adv ? bse_pkg::ST_CALL_A : bse_pkg::ST_CALL_N;
        r.pc      = pc + 24'd4 + disp16;
      end
      bse_pkg::OP_JSR_REG: begin
        push_en  = 1'b1;
        r.states = adv ? bse_pkg::ST_BSR_A : bse_pkg::ST_BSR_N;
        r.pc     = greg[23:0];
      end
      bse_pkg::OP_JSR_ABS: begin
        push_en  = 1'b1;
        push_val = pc + 24'd4;
        r.states = adv ? bse_pkg::ST_CALL_A : bse_pkg::ST_CALL_N;
        r.pc     = {b1, b2, b3};
      end
      bse_pkg::OP_JSR_IND: begin
        push_en  = 1'b1;
        r.states = adv ? bse_pkg::ST_JSR_IND_A : bse_pkg::ST_CALL_N;
        r.pc     = adv ? rd24({16'h0000, b1}) : {8'h00, rd16({16'h0000, b1})};
      end
      bse_pkg::OP_MOVE: begin
        r.move      = (b1 == bse_pkg::SUB_MOVE_B) || (b1 == bse_pkg::SUB_MOVE_W);
        r.move_word = (b1 == bse_pkg::SUB_MOVE_W);
        r.illegal   = ~r.move;
        r.states    = bse_pkg::ST_MOVE_SET;
        r.pc        = pc + 24'd4;
      end
      default: begin
        if (b0[7:4] == 4'h4) begin
          // short form, condition in low nibble
          r.states = bse_pkg::ST_BCC_SHORT;
          r.pc     = cond_true(b0[3:0], condition_code_register) ? pc + 24'd2 + disp8 : pc + 24'd2;
        end else begin
          r.illegal = 1'b1;
        end
      end
    endcase
    if (push_en) begin
      // pre-decrement push, word or long by mode
      r.sp      = adv ? sp - 24'd4 : sp - 24'd2;
      r.wr_addr = adv ? sp - 24'd4 : sp - 24'd2;
      r.wr_data = adv ? {8'h00, push_val} : {push_val[15:0], 16'h0000};
      r.wr_len  = adv ? 3'd4 : 3'd2;
    end
  end

  // ****************************************
  // sequencing
  // ****************************************
  logic wr_op;
  logic start;
  logic commit;
  logic move_live;
  logic copy;
  logic [15:0] left;

  assign wr_op     = psel & penable & pwrite;
  assign start     = wr_op && paddr == bse_pkg::OFF_CTRL && pwdata[bse_pkg::CTRL_START]
                     && state == bse_pkg::BSE_IDLE;
  assign commit    = state == bse_pkg::BSE_EXEC && cnt == 5'd0;
  assign left      = move_word ? count : {8'h00, count[7:0]};
  // skip when count starts at zero (only its low byte for the byte form)
  assign move_live = r.move && (r.move_word ? count != 16'h0000 : count[7:0] != 8'h00);
  assign copy      = state == bse_pkg::BSE_MOVE && sub == bse_pkg::ST_MOVE_LAST;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state <= bse_pkg::BSE_IDLE;
      cnt   <= 5'd0;
      sub   <= 2'd0;
    end else begin
      case (state)
        bse_pkg::BSE_IDLE: begin
          if (start) begin
            state <= bse_pkg::BSE_EXEC;
            cnt   <= r.states - 5'd1;
          end
        end
        bse_pkg::BSE_EXEC: begin
          cnt <= cnt - 5'd1;
          if (commit) begin
            sub <= 2'd0;
            if (r.sleep) begin
              state <= bse_pkg::BSE_SLEEP;
            end else if (move_live) begin
              state <= bse_pkg::BSE_MOVE;
            end else begin
              state <= bse_pkg::BSE_IDLE;
            end
          end
        end
        bse_pkg::BSE_MOVE: begin
          sub <= sub + 2'd1;
          if (copy && left == 16'h0001) begin
            state <= bse_pkg::BSE_IDLE;
          end
        end
        bse_pkg::BSE_SLEEP: begin
          if (wr_op && paddr == bse_pkg::OFF_CTRL && pwdata[bse_pkg::CTRL_WAKE]) begin
            state <= bse_pkg::BSE_IDLE;
          end
        end
        default: state <= bse_pkg::BSE_IDLE;
      endcase
    end
  end

  // ****************************************
  // architectural registers
  // ****************************************
  logic arch_wr;
  assign arch_wr = wr_op && state == bse_pkg::BSE_IDLE;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      insn      <= 32'h00000000;
      pc        <= 24'h000000;
      sp        <= bse_pkg::SP_RESET;
      condition_code_register       <= bse_pkg::CCR_RESET;
      greg      <= 32'h00000000;
      count     <= 16'h0000;
      src       <= 16'h0000;
      dst       <= 16'h0000;
      maddr     <= 8'h00;
      adv       <= 1'b0;
      illegal   <= 1'b0;
      move_word <= 1'b0;
    end else if (commit) begin
      // flags change only where the result says so
      pc        <= r.pc;
      sp        <= r.sp;
      condition_code_register       <= r.condition_code_register;
      greg      <= r.greg;
      illegal   <= r.illegal;
      move_word <= r.move_word;
    end else if (copy) begin
      src <= src + 16'h0001;
      dst <= dst + 16'h0001;
      // byte form leaves the upper count byte alone
      count <= move_word ? count - 16'h0001 : {count[15:8], count[7:0] - 8'h01};
    end else if (arch_wr) begin
      case (paddr)
        bse_pkg::OFF_CTRL:  adv   <= pwdata[bse_pkg::CTRL_ADV];
        bse_pkg::OFF_INSN:  insn  <= pwdata;
        bse_pkg::OFF_PC:    pc    <= pwdata[23:0];
        bse_pkg::OFF_SP:    sp    <= pwdata[23:0];
        bse_pkg::OFF_CCR:   condition_code_register   <= pwdata[7:0];
        bse_pkg::OFF_GREG:  greg  <= pwdata;
        bse_pkg::OFF_COUNT: count <= pwdata[15:0];
        bse_pkg::OFF_SRC:   src   <= pwdata[15:0];
        bse_pkg::OFF_DST:   dst   <= pwdata[15:0];
        bse_pkg::OFF_MADDR: maddr <= pwdata[7:0];
        default: ;
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      elapsed <= 16'h0000;
    end else if (start) begin
      elapsed <= 16'h0001;
    end else if (state == bse_pkg::BSE_EXEC || state == bse_pkg::BSE_MOVE) begin
      elapsed <= (commit && !move_live) || (copy && left == 16'h0001) ? elapsed : elapsed + 16'h0001;
    end
  end

  // no reset on the array: contents are undefined until written
  always_ff @(posedge pclk) begin
    if (commit) begin
      for (int i = 0; i < 4; i++) begin
        if (i < int'(r.wr_len)) begin
          mem[8'(r.wr_addr + 24'(i))] <= r.wr_data[31 - 8 * i -: 8];
        end
      end
    end else if (copy) begin
      mem[dst[7:0]] <= mem[src[7:0]];
    end else if (arch_wr && paddr == bse_pkg::OFF_MDATA) begin
      mem[maddr] <= pwdata[7:0];
    end
  end

  // ****************************************
  // bus answer
  // ****************************************
  logic hit;
  assign hit     = paddr[1:0] == 2'b00 && paddr <= bse_pkg::OFF_MDATA;
  assign pready  = 1'b1;
  // refused: unmapped address, or a write while the core is not idle
  assign pslverr = psel & penable & (~hit | (pwrite & state != bse_pkg::BSE_IDLE));
  assign busy     = state == bse_pkg::BSE_EXEC || state == bse_pkg::BSE_MOVE;
  assign sleeping = state == bse_pkg::BSE_SLEEP;

  // read data is captured in the setup cycle so it leaves a flip-flop
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h00000000;
    end else if (psel && !penable && !pwrite) begin
      case (paddr)
        bse_pkg::OFF_CTRL:   prdata <= {30'h00000000, adv, 1'b0};
        bse_pkg::OFF_INSN:   prdata <= insn;
        bse_pkg::OFF_PC:     prdata <= {8'h00, pc};
        bse_pkg::OFF_SP:     prdata <= {8'h00, sp};
        bse_pkg::OFF_CCR:    prdata <= {24'h000000, condition_code_register};
        bse_pkg::OFF_GREG:   prdata <= greg;
        bse_pkg::OFF_COUNT:  prdata <= {16'h0000, count};
        bse_pkg::OFF_SRC:    prdata <= {16'h0000, src};
        bse_pkg::OFF_DST:    prdata <= {16'h0000, dst};
        bse_pkg::OFF_STATUS: prdata <= {elapsed, 13'h0000, illegal, sleeping, busy};
        bse_pkg::OFF_MADDR:  prdata <= {24'h000000, maddr};
        bse_pkg::OFF_MDATA:  prdata <= {24'h000000, mem[maddr]};
        default:             prdata <= 32'h00000000;
      endcase
    end
  end

endmodule

// file: bse_pkg.sv
package bse_pkg;

  // ****************************************
  // register map and control bits
  // ****************************************
  localparam logic [7:0] OFF_CTRL   = 8'h00;
  localparam logic [7:0] OFF_INSN   = 8'h04;
  localparam logic [7:0] OFF_PC     = 8'h08;
  localparam logic [7:0] OFF_SP     = 8'h0C;
  localparam logic [7:0] OFF_CCR    = 8'h10;
  localparam logic [7:0] OFF_GREG   = 8'h14;
  localparam logic [7:0] OFF_COUNT  = 8'h18;
  localparam logic [7:0] OFF_SRC    = 8'h1C;
  localparam logic [7:0] OFF_DST    = 8'h20;
  localparam logic [7:0] OFF_STATUS = 8'h24;
  localparam logic [7:0] OFF_MADDR  = 8'h28;
  localparam logic [7:0] OFF_MDATA  = 8'h2C;

  localparam int CTRL_START = 0;
  localparam int CTRL_ADV   = 1;
  localparam int CTRL_WAKE  = 2;

  localparam int CCR_I = 7;
  localparam int CCR_N = 3;
  localparam int CCR_Z = 2;
  localparam int CCR_V = 1;
  localparam int CCR_C = 0;

  localparam logic [7:0]  CCR_RESET = 8'h80;
  localparam logic [23:0] SP_RESET  = 24'h0000F0;
  localparam logic [7:0]  VEC_BASE  = 8'h10;
  localparam int          MEM_DEPTH = 256;

  // ****************************************
  // execution state counts
  // ****************************************
  localparam logic [4:0] ST_SHORT     = 5'd2;
  localparam logic [4:0] ST_BCC_SHORT = 5'd4;
  localparam logic [4:0] ST_BCC_LONG  = 5'd6;
  localparam logic [4:0] ST_JMP_REG   = 5'd4;
  localparam logic [4:0] ST_JMP_ABS   = 5'd6;
  localparam logic [4:0] ST_JMP_IND_N = 5'd8;
  localparam logic [4:0] ST_JMP_IND_A = 5'd10;
  localparam logic [4:0] ST_BSR_N     = 5'd6;
  localparam logic [4:0] ST_BSR_A     = 5'd8;
  localparam logic [4:0] ST_CALL_N    = 5'd8;
  localparam logic [4:0] ST_CALL_A    = 5'd10;
  localparam logic [4:0] ST_JSR_IND_A = 5'd12;
  localparam logic [4:0] ST_RET_N     = 5'd8;
  localparam logic [4:0] ST_RET_A     = 5'd10;
  localparam logic [4:0] ST_TRAP_N    = 5'd14;
  localparam logic [4:0] ST_TRAP_A    = 5'd16;
  localparam logic [4:0] ST_RTE       = 5'd10;
  localparam logic [4:0] ST_FLAGS_IND = 5'd6;
  localparam logic [4:0] ST_FLAGS_PTR = 5'd8;
  localparam logic [4:0] ST_MOVE_SET  = 5'd8;
  localparam logic [1:0] ST_MOVE_LAST = 2'd3;

  // ****************************************
  // opcodes
  // ****************************************
  localparam logic [7:0] OP_NOP      = 8'h00;
  localparam logic [7:0] OP_SYS      = 8'h01;
  localparam logic [7:0] OP_STC_REG  = 8'h02;
  localparam logic [7:0] OP_LDC_REG  = 8'h03;
  localparam logic [7:0] OP_OR_CCR   = 8'h04;
  localparam logic [7:0] OP_XOR_CCR  = 8'h05;
  localparam logic [7:0] OP_AND_CCR  = 8'h06;
  localparam logic [7:0] OP_LDC_IMM  = 8'h07;
  localparam logic [7:0] OP_RTS      = 8'h54;
  localparam logic [7:0] OP_BSR8     = 8'h55;
  localparam logic [7:0] OP_RTE      = 8'h56;
  localparam logic [7:0] OP_TRAP     = 8'h57;
  localparam logic [7:0] OP_BCC_LONG = 8'h58;
  localparam logic [7:0] OP_JMP_REG  = 8'h59;
  localparam logic [7:0] OP_JMP_ABS  = 8'h5A;
  localparam logic [7:0] OP_JMP_IND  = 8'h5B;
  localparam logic [7:0] OP_BSR16    = 8'h5C;
  localparam logic [7:0] OP_JSR_REG  = 8'h5D;
  localparam logic [7:0] OP_JSR_ABS  = 8'h5E;
  localparam logic [7:0] OP_JSR_IND  = 8'h5F;
  localparam logic [7:0] OP_MOVE     = 8'h7B;
  localparam logic [7:0] SUB_SLEEP   = 8'h80;
  localparam logic [7:0] SUB_CCR_MEM = 8'h40;
  localparam logic [7:0] SUB_IND     = 8'h69;
  localparam logic [7:0] SUB_PTR     = 8'h6D;
  localparam logic [7:0] SUB_RET     = 8'h70;
  localparam logic [7:0] SUB_MOVE_B  = 8'h5C;
  localparam logic [7:0] SUB_MOVE_W  = 8'hD4;

  typedef enum logic [1:0] {
    BSE_IDLE  = 2'b00,
    BSE_EXEC  = 2'b01,
    BSE_MOVE  = 2'b11,
    BSE_SLEEP = 2'b10
  } bse_state_type;

  typedef struct packed {
    logic [23:0] pc;
    logic [23:0] sp;
    logic [7:0]  condition_code_register;
    logic [31:0] greg;
    logic [4:0]  states;
    logic [23:0] wr_addr;
    logic [31:0] wr_data;
    logic [2:0]  wr_len;
    logic        sleep;
    logic        move;
    logic        move_word;
    logic        illegal;
  } bse_result_type;

endpackage

// file: bse_exec_properties.sv
module bse_exec_properties (
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [7:0]  paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic        busy,
  input wire logic        sleeping
);
  // ****************************************
  // opcode and busy-length tracking
  // ****************************************
  logic [7:0] op_byte;
  logic [7:0] sub_byte;
  logic [4:0] busy_cycles;
  wire logic  acc = psel && penable;
  wire logic  wr_acc = acc && pwrite;
  wire logic  wake = wr_acc && paddr == bse_pkg::OFF_CTRL && pwdata[bse_pkg::CTRL_WAKE];
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      op_byte <= 8'h00;
      sub_byte <= 8'h00;
    end else if (wr_acc && paddr == bse_pkg::OFF_INSN) begin
      op_byte <= pwdata[31:24];
      sub_byte <= pwdata[23:16];
    end
  end
  // counts cycles of the current busy run, read at its falling edge
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) busy_cycles <= 5'h00;
    else busy_cycles <= busy ? busy_cycles + 5'h01 : 5'h00;
  end
  sequence start_s;
    wr_acc && paddr == bse_pkg::OFF_CTRL && pwdata[bse_pkg::CTRL_START] && !busy && !sleeping;
  endsequence
  sequence done_s(logic [7:0] op);
    $fell(busy) && op_byte == op;
  endsequence
  ready_high_a: assert property (pready) else $error("pready low");
  err_phase_a: assert property (pslverr |-> acc) else $error("pslverr outside access");
  unmapped_err_a: assert property (acc && paddr > 8'h2C |-> pslverr) else $error("no error");
  start_busy_a: assert property (start_s |=> busy) else $error("start did not raise busy");
  refuse_write_a: assert property (wr_acc && (busy || sleeping) && !wake |-> pslverr)
    else $error("write while active not refused");
  nop_states_a: assert property (done_s(bse_pkg::OP_NOP) |-> busy_cycles == 5'h02)
    else $error("nop length wrong");
  branch_states_a: assert property (done_s(bse_pkg::OP_BCC_LONG) |-> busy_cycles == 5'h06)
    else $error("long branch length wrong");
  trap_states_a: assert property (done_s(bse_pkg::OP_TRAP) |-> busy_cycles == 5'h0E)
    else $error("trap length wrong");
  sleep_entry_a: assert property (done_s(bse_pkg::OP_SYS) ##0 sub_byte == bse_pkg::SUB_SLEEP
    |-> ##[0:1] sleeping) else $error("sleep not entered");
  sleep_hold_a: assert property (sleeping && !wake |=> sleeping) else $error("sleep left");
endmodule

bind bse_exec bse_exec_properties bse_exec_properties_i (.pclk, .presetn, .psel, .penable,
  .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .busy, .sleeping);

// file: bse_apb_host.sv
module bse_apb_host (
  input  wire logic        pclk,
  output logic             psel,
  output logic             penable,
  output logic             pwrite,
  output logic      [7:0]  paddr,
  output logic      [31:0] pwdata,
  input  wire logic [31:0] prdata,
  input  wire logic        pready
);
  timeunit 1ns;
  timeprecision 1ps;
  // ****************************************
  // apb master transfer
  // ****************************************
  initial begin
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
  end
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
                      output logic [31:0] q);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    q = prdata;
    psel <= 1'b0;
    penable <= 1'b0;
    // released lines scrambled so stale values are never trusted
    paddr <= ~a;
    pwdata <= ~d;
  endtask
endmodule

// file: test_branch_syscall_exec.sv
module test_branch_syscall_exec;
  timeunit 1ns;
  timeprecision 1ps;
  logic        pclk;
  logic        presetn;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [7:0]  paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        busy;
  logic        sleeping;
  logic        adv;
  logic [31:0] e;
  int          fails;
  int          tests_run;
  logic [7:0]  fop [5] = '{bse_pkg::OP_LDC_IMM, bse_pkg::OP_AND_CCR, bse_pkg::OP_OR_CCR,
                           bse_pkg::OP_XOR_CCR, bse_pkg::OP_NOP};
  logic [7:0]  fres [5] = '{8'h5A, 8'h42, 8'hDB, 8'h99, 8'hC3};
  bse_exec bse_exec_i (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
    .pready, .pslverr, .busy, .sleeping);
  bse_apb_host bse_apb_host_i (.pclk, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
    .pready);
  // ****************************************
  // helpers
  // ****************************************
  initial begin
    pclk = 1'b0;
    forever #2.5 pclk = ~pclk;
  end
  task automatic chk(input logic [31:0] s, input logic [31:0] x);
    tests_run++;
    if (s !== x) begin
      fails++;
      $display("mismatch at %0t: saw %h want %h", $time, s, x);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    bse_apb_host_i.xfer(1'b1, a, d, q);
  endtask
  task automatic rc(input logic [7:0] a, input logic [31:0] x);
    logic [31:0] q;
    bse_apb_host_i.xfer(1'b0, a, 32'h0, q);
    chk(q, x);
  endtask
  task automatic mw(input logic [7:0] a, input logic [7:0] d);
    wr(bse_pkg::OFF_MADDR, {24'h0, a});
    wr(bse_pkg::OFF_MDATA, {24'h0, d});
  endtask
  task automatic mc(input logic [7:0] a, input logic [31:0] x);
    wr(bse_pkg::OFF_MADDR, {24'h0, a});
    rc(bse_pkg::OFF_MDATA, x);
  endtask
  // waits on busy itself, then checks the elapsed count in STATUS against st
  task automatic ex(input logic [31:0] i, input int st);
    logic [31:0] q;
    wr(bse_pkg::OFF_INSN, i);
    wr(bse_pkg::OFF_CTRL, {30'h0, adv, 1'b1});
    for (int k = 0; k < 3 && busy !== 1'b1; k++) @(negedge pclk);
    while (busy !== 1'b0) @(negedge pclk);
    bse_apb_host_i.xfer(1'b0, bse_pkg::OFF_STATUS, 32'h0, q);
    chk({16'h0, q[31:16]}, 32'(st));
  endtask
  function automatic logic taken(input logic [3:0] c, input logic [3:0] f);
    logic [7:0] b;
    b = {f[2] | (f[3] ^ f[1]), f[3] ^ f[1], f[3], f[1], f[2], f[0], f[0] | f[2], 1'b0};
    return c[0] ? b[c[3:1]] : !b[c[3:1]];
  endfunction
  task automatic wrap_up;
    $display("comparisons %0d mismatches %0d", tests_run, fails);
    if (fails == 0 && tests_run > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  initial begin
    #400000;
    fails++;
    wrap_up();
  end
  // ****************************************
  // tests
  // ****************************************
  initial begin
    presetn = 1'b0;
    adv = 1'b0;
    fails = 0;
    tests_run = 0;
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    rc(bse_pkg::OFF_PC, 32'h0);
    rc(bse_pkg::OFF_SP, 32'hF0);
    rc(bse_pkg::OFF_CCR, 32'h80);
    rc(8'h30, 32'h0);
    $display("test reset done");
    for (int n = 0; n < 512; n++) begin
      wr(bse_pkg::OFF_PC, 32'h100);
      wr(bse_pkg::OFF_CCR, 32'(n[8:5]));
      e = taken(n[4:1], n[8:5]) ? (n[0] ? 32'hF4 : 32'h82) : (n[0] ? 32'h104 : 32'h102);
      if (n[0]) ex({bse_pkg::OP_BCC_LONG, n[4:1], 20'h0FFF0}, 6);
      else ex({4'h4, n[4:1], 8'h80, 16'h0000}, 4);
      rc(bse_pkg::OFF_PC, e);
      rc(bse_pkg::OFF_CCR, 32'(n[8:5]));
    end
    $display("test branch done");
    ex({bse_pkg::OP_JMP_ABS, 24'h001234}, 6);
    rc(bse_pkg::OFF_PC, 32'h1234);
    wr(bse_pkg::OFF_GREG, 32'h456);
    ex({bse_pkg::OP_JMP_REG, 24'h0}, 4);
    rc(bse_pkg::OFF_PC, 32'h456);
    for (int m = 1; m >= 0; m--) begin
      adv = m[0];
      wr(bse_pkg::OFF_CTRL, {30'h0, adv, 1'b0});
      wr(bse_pkg::OFF_PC, 32'h100);
      ex({bse_pkg::OP_BSR8, 8'h10, 16'h0}, 6 + 2 * m);
      rc(bse_pkg::OFF_PC, 32'h112);
      rc(bse_pkg::OFF_SP, 32'(238 - 2 * m));
      mc(8'hEE, 32'h01);
      mc(8'hEF, 32'h02);
      ex({bse_pkg::OP_RTS, bse_pkg::SUB_RET, 16'h0}, 8 + 2 * m);
      rc(bse_pkg::OFF_PC, 32'h102);
      rc(bse_pkg::OFF_SP, 32'hF0);
    end
    $display("test call done");
    mw(8'h12, 8'h03);
    mw(8'h13, 8'h40);
    wr(bse_pkg::OFF_CCR, 32'h05);
    wr(bse_pkg::OFF_PC, 32'h100);
    ex({bse_pkg::OP_TRAP, 8'h10, 16'h0}, 14);
    rc(bse_pkg::OFF_PC, 32'h340);
    rc(bse_pkg::OFF_CCR, 32'h85);
    rc(bse_pkg::OFF_SP, 32'hEC);
    mc(8'hEC, 32'h05);
    ex({bse_pkg::OP_RTE, bse_pkg::SUB_RET, 16'h0}, 10);
    rc(bse_pkg::OFF_PC, 32'h102);
    rc(bse_pkg::OFF_CCR, 32'h05);
    $display("test trap done");
    for (int j = 0; j < 5; j++) begin
      wr(bse_pkg::OFF_CCR, 32'hC3);
      wr(bse_pkg::OFF_PC, 32'h200);
      ex({fop[j], 8'h5A & {8{|fop[j]}}, 16'h0}, 2);
      rc(bse_pkg::OFF_CCR, {24'h0, fres[j]});
      rc(bse_pkg::OFF_PC, 32'h202);
    end
    wr(bse_pkg::OFF_GREG, 32'h30);
    mw(8'h30, 8'h8A);
    ex({bse_pkg::OP_SYS, bse_pkg::SUB_CCR_MEM, bse_pkg::SUB_PTR, 8'h00}, 8);
    rc(bse_pkg::OFF_CCR, 32'h8A);
    rc(bse_pkg::OFF_GREG, 32'h32);
    ex({bse_pkg::OP_SYS, bse_pkg::SUB_CCR_MEM, bse_pkg::SUB_PTR, 8'h80}, 8);
    rc(bse_pkg::OFF_GREG, 32'h30);
    mc(8'h31, 32'h8A);
    rc(bse_pkg::OFF_CCR, 32'h8A);
    ex({bse_pkg::OP_JMP_IND, 8'h12, 16'h0}, 8);
    rc(bse_pkg::OFF_PC, 32'h340);
    $display("test flags done");
    wr(bse_pkg::OFF_COUNT, 32'h0103);
    wr(bse_pkg::OFF_SRC, 32'h40);
    wr(bse_pkg::OFF_DST, 32'h60);
    for (int j = 0; j < 3; j++) mw(8'(64 + j), 8'(160 + j));
    ex({bse_pkg::OP_MOVE, bse_pkg::SUB_MOVE_B, 16'h0}, 20);
    rc(bse_pkg::OFF_COUNT, 32'h0100);
    rc(bse_pkg::OFF_DST, 32'h63);
    for (int j = 0; j < 3; j++) mc(8'(96 + j), 32'(160 + j));
    ex({bse_pkg::OP_MOVE, bse_pkg::SUB_MOVE_B, 16'h0}, 8);
    rc(bse_pkg::OFF_SRC, 32'h43);
    wr(bse_pkg::OFF_COUNT, 32'h2);
    ex({bse_pkg::OP_MOVE, bse_pkg::SUB_MOVE_W, 16'h0}, 16);
    rc(bse_pkg::OFF_SRC, 32'h45);
    $display("test move done");
    wr(bse_pkg::OFF_CCR, 32'h21);
    ex({bse_pkg::OP_SYS, bse_pkg::SUB_SLEEP, 16'h0}, 2);
    chk({31'h0, sleeping}, 32'h1);
    wr(bse_pkg::OFF_CCR, 32'h00);
    rc(bse_pkg::OFF_CCR, 32'h21);
    wr(bse_pkg::OFF_CTRL, 32'h4);
    @(negedge pclk);
    chk({31'h0, sleeping}, 32'h0);
    $display("test sleep done");
    wrap_up();
  end
endmodule
